/* dv/ocs_clock_select_sva.sv */
// Port-level checker for the clock select block.
// Assumes the option byte changes only while reset is held.
`timescale 1ns/1ps
module ocs_clock_select_sva (
  input wire clk,
  input wire rstn,
  input wire hsel,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [17:0] haddr,
  input wire [1:0] htrans,
  input wire [31:0] hwdata,
  input wire [7:0] nv_option_byte,
  input wire stop_mode,
  input wire internal_osc_clock,
  input wire resistor_cap_osc_clock,
  input wire crystal_osc_clock,
  input wire crystal_amp_out,
  input wire bus_clock,
  input wire internal_osc_en,
  input wire rc_osc_en,
  input wire crystal_osc_en,
  input wire main_ref_clock,
  input wire pll_ref_clock,
  input wire timebase_ref_clock,
  input wire watchdog_ref_clock,
  input wire osc_output_pin_o,
  input wire osc_output_pin_oe
);
  // ==================================
  // Shadow of the config register, snooped from the bus
  reg wr_p_r;
  reg [4:0] cfg_r;
  wire [1:0] sel = nv_option_byte[1:0];
  wire [1:0] ts = cfg_r[1:0];
  wire ic = internal_osc_clock & internal_osc_en;
  wire rc = resistor_cap_osc_clock & rc_osc_en;
  wire xc = crystal_osc_clock & crystal_osc_en;
  wire msrc = (sel == 2'h1 & ic) | (sel == 2'h2 & rc) | (sel == 2'h3 & xc);
  wire tsrc = (ts == 2'h0 & ic) | (ts == 2'h1 & sel == 2'h2 & rc)
    | (ts == 2'h2 & sel == 2'h3 & xc);
  wire pin = sel == 2'h3 ? crystal_amp_out : (sel != 2'h0 & bus_clock);
  always @(posedge clk) begin
    if (!rstn) begin
      wr_p_r <= 1'b0;
      cfg_r <= 5'h00;
    end else begin
      wr_p_r <= hsel & hready & htrans[1] & hwrite & (haddr == 18'h00074);
      if (wr_p_r)
        cfg_r <= hwdata[4:0];
    end
  end
  // ==================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_int_run: assert property (
    internal_osc_en == !(stop_mode & cfg_r[4])) else $error("int enable");
  a_rc_enable: assert property (
    $past(rstn) |-> rc_osc_en == (sel == 2'h2 & (!stop_mode | cfg_r[2])))
    else $error("rc enable");
  a_xtal_enable: assert property (
    $past(rstn) |-> crystal_osc_en == (sel == 2'h3 & (!stop_mode | cfg_r[3])))
    else $error("crystal enable");
  a_osc_excl: assert property (
    !(rc_osc_en & crystal_osc_en)) else $error("both enabled");
  a_main_ref: assert property (
    $past(rstn) & $past(rstn, 2) |-> main_ref_clock == $past(msrc))
    else $error("main ref wrong");
  a_pll_copy: assert property (
    $past(rstn) |-> pll_ref_clock == $past(main_ref_clock))
    else $error("pll ref wrong");
  a_tb_ref: assert property (
    $past(rstn) & $past(rstn, 2) |-> timebase_ref_clock == $past(tsrc))
    else $error("timebase ref wrong");
  a_wdog_ref: assert property (
    $past(rstn) |-> watchdog_ref_clock == $past(ic)) else $error("wdog ref");
  a_pin_drive: assert property (
    $past(rstn) & $past(rstn, 2) |-> osc_output_pin_o == $past(pin)
    && osc_output_pin_oe == (sel != 2'h0)) else $error("pin wrong");
  a_bus_okay: assert property (
    hreadyout & !hresp) else $error("bus response");
endmodule // ocs_clock_select_sva
bind ocs_clock_select ocs_clock_select_sva u_ocs_clock_select_sva (.*);

/* dv/ocs_osc_model.sv */
// Oscillator source model feeding the clock select block.
// Assumes all levels move on clk edges, as the block samples them.
`timescale 1ns/1ps
module ocs_osc_model (
  input wire clk,
  input wire int_en,
  input wire rc_en,
  input wire xt_en,
  output reg int_clk = 1'b0,
  output reg rc_clk = 1'b0,
  output reg xt_clk = 1'b0,
  output reg bus_clk = 1'b0,
  output wire amp_out
);
  reg [3:0] cnt_r = 4'h0;
  // ==================================
  // Sources
  // Stopped sources rest low so a leak shows up
  always @(posedge clk) begin
    cnt_r <= cnt_r + 4'h1;
    int_clk <= int_en & ~int_clk;
    rc_clk <= rc_en & (cnt_r[0] ^ rc_clk);
    xt_clk <= xt_en & cnt_r[2];
    bus_clk <= ~bus_clk;
  end
  assign amp_out = xt_en & ~xt_clk;
endmodule // ocs_osc_model

/* dv/tb_ocs_clock_select.sv */
// Testbench for the clock select block with an oscillator model.
// Assumes a zero-wait slave; option byte is changed only in reset.
`timescale 1ns/1ps
module tb_ocs_clock_select;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg hsel = 1'b0;
  reg [17:0] haddr = 18'h00000;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h00000000;
  reg [7:0] nv_option_byte = 8'h00;
  reg stop_mode = 1'b0;
  wire hready, ic, rcc, xc, amp, bc, ie, re, xe, oe;
  wire mr, pr, tr, wdc, po;
  wire [31:0] hrdata;
  integer errors = 0, samples_checked = 0, seed = 32448, m, k, n;
  reg [31:0] rd, c;
  reg [7:0] ob;
  reg [3:0] e;
  reg [3:0] ex;
  reg pm;
  reg tv;
  ocs_clock_select u_ocs_clock_select (.clk(clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(), .hrdata(hrdata), .nv_option_byte(nv_option_byte),
    .stop_mode(stop_mode), .internal_osc_clock(ic),
    .resistor_cap_osc_clock(rcc), .crystal_osc_clock(xc),
    .crystal_amp_out(amp), .bus_clock(bc), .internal_osc_en(ie),
    .rc_osc_en(re), .crystal_osc_en(xe), .main_ref_clock(mr),
    .pll_ref_clock(pr), .timebase_ref_clock(tr),
    .watchdog_ref_clock(wdc), .osc_output_pin_o(po),
    .osc_output_pin_oe(oe));
  ocs_osc_model u_ocs_osc_model (.clk(clk), .int_en(ie), .rc_en(re),
    .xt_en(xe), .int_clk(ic), .rc_clk(rcc), .xt_clk(xc), .bus_clk(bc),
    .amp_out(amp));
  // ==================================
  // Clock, bus and check tasks
  initial forever #2.5 clk = ~clk;
  task bus(input wr, input [17:0] a, input [31:0] wd);
    begin
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge clk);
      while (!hready) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (!hready) @(posedge clk);
      rd = hrdata;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks=%0d mismatches=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // ==================================
  // Main sequence: every main code, every timebase code, stop on/off
  initial begin
    for (m = 0; m < 4; m = m + 1) begin
      c = $random(seed);
      ob = c[7:0];
      ob[1:0] = m[1:0];
      rstn <= 1'b0;
      nv_option_byte <= ob;
      stop_mode <= 1'b0;
      repeat (4) @(posedge clk);
      chk({31'h0, ie}, 32'h1);
      rstn <= 1'b1;
      bus(1'b1, 18'h3FF3C, ~{24'h0, ob});
      bus(1'b0, 18'h3FF3C, 32'h0);
      chk(rd, {24'h0, ob});
      bus(1'b0, 18'h00100, 32'h0);
      chk(rd, 32'h0);
      for (k = 0; k < 8; k = k + 1) begin
        c = $random(seed);
        c[1:0] = k[1:0];
        stop_mode <= k[2];
        bus(1'b1, 18'h00074, c);
        bus(1'b0, 18'h00074, 32'h0);
        chk(rd, c & 32'h1F);
        e = {k[2], m == 3 && (!k[2] || c[3]), m == 2 && (!k[2] || c[2]),
          !(k[2] && c[4])};
        tv = c[1:0] == 0 || (c[1:0] == 1 && m == 2) ||
          (c[1:0] == 2 && m == 3);
        bus(1'b0, 18'h00078, 32'h0);
        chk(rd, {26'h0, tv, m != 0, e});
        chk({28'h0, xe, re, ie, oe}, {28'h0, e[2:0], m != 0});
        // Outputs trail the sampled sources by one edge, pll by two
        for (n = 0; n < 20; n = n + 1) begin
          @(posedge clk);
          if (n > 0)
            chk({28'h0, mr, tr, wdc, po}, {28'h0, ex});
          if (n > 1)
            chk({31'h0, pr}, {31'h0, pm});
          pm = ex[3];
          ex[3] = (m == 1 && ic && e[0]) || (m == 2 && rcc && e[1]) ||
            (m == 3 && xc && e[2]);
          ex[2] = (c[1:0] == 0 && ic && e[0]) ||
            (c[1:0] == 1 && m == 2 && rcc && e[1]) ||
            (c[1:0] == 2 && m == 3 && xc && e[2]);
          ex[1] = ic && e[0];
          ex[0] = m == 3 ? amp : (m != 0 && bc);
        end
      end
      $display("main code %0d done", m);
    end
    summarize;
  end
  // Hang guard, well beyond the expected run
  initial begin
    repeat (6000) @(posedge clk);
    errors = errors + 1;
    $display("watchdog expired");
    summarize;
  end
endmodule // tb_ocs_clock_select

/* rtl/ocs_clock_select.v */
// Oscillator reference clock selection with an AHB-Lite register slave.
// Assumes oscillator clocks, bus clock and stop request are synchronous
// to clk; a single AHB-Lite master; option byte held static by storage.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`include "ocs_defines.vh"

module ocs_clock_select (
  clk,
  rstn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hresp,
  hrdata,
  nv_option_byte,
  stop_mode,
  internal_osc_clock,
  resistor_cap_osc_clock,
  crystal_osc_clock,
  crystal_amp_out,
  bus_clock,
  internal_osc_en,
  rc_osc_en,
  crystal_osc_en,
  main_ref_clock,
  pll_ref_clock,
  timebase_ref_clock,
  watchdog_ref_clock,
  osc_output_pin_o,
  osc_output_pin_oe
);
  input wire clk;
  input wire rstn;
  input wire hsel;
  input wire [`OCS_ADDR_W-1:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire [31:0] hwdata;
  input wire hready;
  output wire hreadyout;
  output wire hresp;
  output reg [31:0] hrdata;
  input wire [7:0] nv_option_byte;
  input wire stop_mode;
  input wire internal_osc_clock;
  input wire resistor_cap_osc_clock;
  input wire crystal_osc_clock;
  input wire crystal_amp_out;
  input wire bus_clock;
  output wire internal_osc_en;
  output wire rc_osc_en;
  output wire crystal_osc_en;
  output reg main_ref_clock;
  output reg pll_ref_clock;
  output reg timebase_ref_clock;
  output reg watchdog_ref_clock;
  output reg osc_output_pin_o;
  output reg osc_output_pin_oe;

  // ==========================================================
  // Helpers
  function [`OCS_ADDR_W-1:0] ocs_byte_addr;
    input [15:0] idx;
    begin
      ocs_byte_addr = {idx, 2'b00};
    end
  endfunction

  function ocs_pick;
    input [1:0] src;
    input int_c;
    input rc_c;
    input xt_c;
    begin
      case (src)
        `OCS_SRC_INT: ocs_pick = int_c;
        `OCS_SRC_RC: ocs_pick = rc_c;
        `OCS_SRC_XTAL: ocs_pick = xt_c;
        default: ocs_pick = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // Registers
  reg [7:0] clk_cfg_r;
  reg [7:0] clk_cfg_nxt;
  reg [7:0] opt_byte_r;
  reg opt_loaded_r;
  reg wr_pend_r;
  reg [`OCS_ADDR_W-1:0] wr_addr_r;
  reg [31:0] rdata_nxt;
  wire addr_phase;
  wire [1:0] main_sel;
  wire [1:0] tb_sel;
  wire [7:0] status;
  reg [1:0] main_src;
  reg [1:0] tb_src;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & hready & htrans[1];

  // ==========================================================
  // Option byte capture
  // Taken after reset release so the flop never loads a port in reset
  always @(posedge clk) begin
    if (!rstn) begin
      opt_byte_r <= `OCS_OPT_BYTE_RST;
      opt_loaded_r <= 1'b0;
    end else if (!opt_loaded_r) begin
      opt_byte_r <= nv_option_byte;
      opt_loaded_r <= 1'b1;
    end
  end

  assign main_sel = {opt_byte_r[`OCS_OPT_SEL_HI],
                     opt_byte_r[`OCS_OPT_SEL_LO]};
  assign tb_sel = {clk_cfg_r[`OCS_CFG_TB_SEL_HI],
                   clk_cfg_r[`OCS_CFG_TB_SEL_LO]};

  // ==========================================================
  // Bus slave, zero wait states
  always @(posedge clk) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= {`OCS_ADDR_W{1'b0}};
    end else begin
      wr_pend_r <= addr_phase & hwrite;
      wr_addr_r <= haddr;
    end
  end

  always @* begin
    clk_cfg_nxt = clk_cfg_r;
    if (wr_pend_r &&
        wr_addr_r == ocs_byte_addr(`OCS_IDX_CLK_CFG)) begin
      clk_cfg_nxt = hwdata[7:0] & `OCS_CFG_MASK;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      clk_cfg_r <= `OCS_CLK_CFG_RST;
    end else begin
      clk_cfg_r <= clk_cfg_nxt;
    end
  end

  // Read data prepared in the address phase; config read sees the
  // value after any write completing in the same cycle
  always @* begin
    rdata_nxt = 32'h00000000;
    if (haddr == ocs_byte_addr(`OCS_IDX_CLK_CFG)) begin
      rdata_nxt = {24'h000000, clk_cfg_nxt};
    end else if (haddr == ocs_byte_addr(`OCS_IDX_OPT_BYTE)) begin
      rdata_nxt = {24'h000000, opt_byte_r};
    end else if (haddr == ocs_byte_addr(`OCS_IDX_STATUS)) begin
      rdata_nxt = {24'h000000, status};
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

  // ==========================================================
  // Oscillator enables
  // Internal on out of reset
  // Stop gates internal only with disable bit
  assign internal_osc_en = !rstn ? 1'b1 :
    !(stop_mode & clk_cfg_r[`OCS_CFG_INT_DIS]);

  // Only the selected one of RC and crystal
  // Stop halts unless keep bit set
  assign rc_osc_en = rstn & opt_loaded_r &&
    main_sel == `OCS_MAIN_RC &&
    (!stop_mode || clk_cfg_r[`OCS_CFG_RC_KEEP]);
  assign crystal_osc_en = rstn & opt_loaded_r &&
    main_sel == `OCS_MAIN_XTAL &&
    (!stop_mode || clk_cfg_r[`OCS_CFG_XTAL_KEEP]);

  assign status = {2'b00,
                   tb_src != `OCS_SRC_NONE,
                   main_src != `OCS_SRC_NONE,
                   stop_mode,
                   crystal_osc_en,
                   rc_osc_en,
                   internal_osc_en};

  // ==========================================================
  // Source decode
  always @* begin
    case (main_sel)
      `OCS_MAIN_INT: main_src = `OCS_SRC_INT;
      `OCS_MAIN_RC: main_src = `OCS_SRC_RC;
      `OCS_MAIN_XTAL: main_src = `OCS_SRC_XTAL;
      default: main_src = `OCS_SRC_NONE;
    endcase
    // External sources only if also main
    case (tb_sel)
      `OCS_TB_INT: tb_src = `OCS_SRC_INT;
      `OCS_TB_RC: tb_src = (main_sel == `OCS_MAIN_RC) ?
                           `OCS_SRC_RC : `OCS_SRC_NONE;
      `OCS_TB_XTAL: tb_src = (main_sel == `OCS_MAIN_XTAL) ?
                             `OCS_SRC_XTAL : `OCS_SRC_NONE;
      default: tb_src = `OCS_SRC_NONE;
    endcase
  end

  // ==========================================================
  // Clock outputs
  // Registered muxing trades one cycle of delay for glitch-free edges;
  // a disabled oscillator simply contributes a held-low level
  always @(posedge clk) begin
    if (!rstn) begin
      main_ref_clock <= 1'b0;
      pll_ref_clock <= 1'b0;
      timebase_ref_clock <= 1'b0;
      watchdog_ref_clock <= 1'b0;
    end else begin
      main_ref_clock <= ocs_pick(main_src,
        internal_osc_clock & internal_osc_en,
        resistor_cap_osc_clock & rc_osc_en,
        crystal_osc_clock & crystal_osc_en);
      pll_ref_clock <= main_ref_clock;
      timebase_ref_clock <= ocs_pick(tb_src,
        internal_osc_clock & internal_osc_en,
        resistor_cap_osc_clock & rc_osc_en,
        crystal_osc_clock & crystal_osc_en);
      watchdog_ref_clock <= internal_osc_clock & internal_osc_en;
    end
  end

  // ==========================================================
  // Second oscillator pin
  always @(posedge clk) begin
    if (!rstn) begin
      osc_output_pin_o <= 1'b0;
      osc_output_pin_oe <= 1'b0;
    end else begin
      case (main_src)
        `OCS_SRC_INT,
        `OCS_SRC_RC: begin
          osc_output_pin_o <= bus_clock;
          osc_output_pin_oe <= 1'b1;
        end
        `OCS_SRC_XTAL: begin
          osc_output_pin_o <= crystal_amp_out;
          osc_output_pin_oe <= 1'b1;
        end
        default: begin
          osc_output_pin_o <= 1'b0;
          osc_output_pin_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule // ocs_clock_select

/* shared/ocs_defines.vh */
// Constants for the oscillator clock select block.
// Included by the design file; holds definitions only.
`ifndef OCS_DEFINES_VH
`define OCS_DEFINES_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define OCS_IDX_CLK_CFG 16'h001D
`define OCS_IDX_OPT_BYTE 16'hFFCF
`define OCS_IDX_STATUS 16'h001E
`define OCS_ADDR_W 18

// ==========================================================
// Reset values
`define OCS_CLK_CFG_RST 8'h00
`define OCS_OPT_BYTE_RST 8'h00

// ==========================================================
// Clock option config fields
`define OCS_CFG_TB_SEL_LO 0
`define OCS_CFG_TB_SEL_HI 1
`define OCS_CFG_RC_KEEP 2
`define OCS_CFG_XTAL_KEEP 3
`define OCS_CFG_INT_DIS 4
`define OCS_CFG_MASK 8'h1F

// ==========================================================
// Oscillator option byte fields
`define OCS_OPT_SEL_LO 0
`define OCS_OPT_SEL_HI 1

// ==========================================================
// Status fields
`define OCS_ST_INT_EN 0
`define OCS_ST_RC_EN 1
`define OCS_ST_XTAL_EN 2
`define OCS_ST_STOP 3
`define OCS_ST_MAIN_OK 4
`define OCS_ST_TB_OK 5

// ==========================================================
// Select codes, main reference
`define OCS_MAIN_NONE 2'h0
`define OCS_MAIN_INT 2'h1
`define OCS_MAIN_RC 2'h2
`define OCS_MAIN_XTAL 2'h3

// ==========================================================
// Select codes, timebase reference
`define OCS_TB_INT 2'h0
`define OCS_TB_RC 2'h1
`define OCS_TB_XTAL 2'h2
`define OCS_TB_NONE 2'h3

// ==========================================================
// Source identifiers for the clock mux function
`define OCS_SRC_NONE 2'h0
`define OCS_SRC_INT 2'h1
`define OCS_SRC_RC 2'h2
`define OCS_SRC_XTAL 2'h3

`endif
